// File: design/bsrp_defines.svh
`ifndef BSRP_DEFINES_SVH
`define BSRP_DEFINES_SVH
`define BSRP_WORD_BITS   16
`define BSRP_BIT_W       4
`define BSRP_LAST_BIT    4'hf
`define BSRP_BIT_ZERO    4'h0
`define BSRP_RW_BIT      0
`define BSRP_ADDR_LSB    1
`define BSRP_ADDR_W      5
`define BSRP_DATA_LSB    6
`define BSRP_DATA_W      10
`define BSRP_RW_WRITE    1'h0
`define BSRP_RW_READ     1'h1
`define BSRP_BUF_DEPTH   2
`endif

// File: design/bsrp_pkg.sv
package bsrp_pkg;
    typedef logic [15:0] bsrp_word_t;
    typedef logic [4:0]  bsrp_addr_t;
    typedef logic [9:0]  bsrp_data_t;
    typedef enum logic [1:0]
    {
        BSRP_IDLE = 2'b00,
        BSRP_SHIFT = 2'b01
    } bsrp_ser_t;
endpackage : bsrp_pkg

// File: design/bsrp_link_if.sv
// Serial link; host drives rx side, device drives tx side.
interface bsrp_link_if;
    logic master_clock_active_flag;
    logic rx_frame_sync;
    logic serial_rx_line;
    logic tx_frame_sync;
    logic serial_tx_line;
    logic host_interrupt_line;
    modport dev
    (
        input  master_clock_active_flag,
        input  rx_frame_sync,
        input  serial_rx_line,
        output tx_frame_sync,
        output serial_tx_line,
        output host_interrupt_line
    );
    modport host
    (
        output master_clock_active_flag,
        output rx_frame_sync,
        output serial_rx_line,
        input  tx_frame_sync,
        input  serial_tx_line,
        input  host_interrupt_line
    );
endinterface : bsrp_link_if

// File: design/bsrp_device.sv
// Contract
// - Receive and transmit paths double buffered
// - Every transfer is framed 16-bit word
// - Serial logic runs on master clock
// - Port reads and writes every register
// - Burst lends transmit path to codec
// - Host frames every word it sends
// - Device frames every word it sends
// - Host idle while clock active flag low
// - Single frame pulse one bit before MSB
// - Adjacent pulse coincides with previous LSB
// - Arbiter grants bus, routes read data
// - Arbiter merges interrupts into host line
// - Inputs sampled on master clock fall
// - Outputs launched on master clock fall
// - Bit 0 zero writes, one reads
// - Bits 1-5 address, 6-15 data
// - Burst words carry 16 sample bits
`include "bsrp_defines.svh"
module bsrp_device
    import bsrp_pkg::*;
(
    input  wire logic       clock_in,       // Master clock, falling-edge logic
    input  wire logic       rstn_in,        // Async reset, active low
    input  wire logic       clk_en_in,      // Freezes state when low
    bsrp_link_if.dev        link,           // Serial link
    input  wire logic       burst_rx_in,    // Burst reception active
    input  wire logic       iq_valid_in,    // Codec sample available
    input  wire bsrp_word_t iq_word_in,     // Codec sample
    output logic            iq_ready_out,   // Sample accepted
    input  wire logic       usp_req_in,     // Controller port request
    input  wire logic       usp_rd_in,      // Controller port read
    input  wire bsrp_addr_t usp_addr_in,    // Controller port address
    input  wire bsrp_data_t usp_wdata_in,   // Controller port data
    output logic            usp_gnt_out,    // Controller port granted
    output bsrp_data_t      usp_rdata_out,  // Controller read data
    output logic            usp_rvalid_out, // Controller read valid
    output logic            reg_we_out,     // Internal bus write
    output bsrp_addr_t      reg_addr_out,   // Internal bus address
    output bsrp_data_t      reg_wdata_out,  // Internal bus data
    input  wire bsrp_data_t reg_rdata_in,   // Internal bus read data
    input  wire logic       irq_monitoring_adc_in,    // Monitoring ADC interrupt
    input  wire logic       irq_bci_in,     // Charger interface interrupt
    input  wire logic       irq_power_control_unit_in     // Power control interrupt
);
    // everything is on the falling edge
    wire logic clk_n = ~clock_in;
    logic [1:0] fs_sync_q;
    logic [1:0] rx_sync_q;
    logic [1:0] act_sync_q;
    logic [`BSRP_BIT_W-1:0] rx_cnt_q;
    logic       rx_busy_q;
    bsrp_word_t rx_shift_q;
    logic       rx_done_q;
    bsrp_word_t rx_hold_q;
    logic       host_grant_q;
    logic       rd_pend_q;
    bsrp_data_t rd_data_q;
    logic       irq_q;
    bsrp_word_t buf_q [`BSRP_BUF_DEPTH];
    logic [1:0] buf_cnt_q;
    logic       buf_wr_q;
    logic       buf_rd_q;
    bsrp_ser_t  tx_st_q;
    logic [`BSRP_BIT_W-1:0] tx_cnt_q;
    bsrp_word_t tx_shift_q;
    logic       tx_fs_q;
    logic       tx_line_q;
    logic       fs_s;
    logic       src_valid;
    bsrp_word_t src_word;
    logic       buf_push;
    logic       buf_pop;
    logic       load_tx;
    logic       rx_word_ok;
    assign fs_s = fs_sync_q[1];

    // Two-stage synchronisers; stage 0 read only by stage 1
    always_ff @(posedge clk_n or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            fs_sync_q  <= 2'h0;
            rx_sync_q  <= 2'h0;
            act_sync_q <= 2'h0;
        end
        else if (clk_en_in)
        begin
            fs_sync_q  <= {fs_sync_q[0], link.rx_frame_sync};
            rx_sync_q  <= {rx_sync_q[0], link.serial_rx_line};
            act_sync_q <= {act_sync_q[0], link.master_clock_active_flag};
        end
    end

    // Receive shifter; a frame pulse at the LSB restarts it, one mid-word is ignored
    always_ff @(posedge clk_n or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rx_cnt_q   <= `BSRP_BIT_ZERO;
            rx_busy_q  <= 1'h0;
            rx_shift_q <= 16'h0000;
            rx_done_q  <= 1'h0;
        end
        else if (clk_en_in)
        begin
            rx_done_q <= 1'h0;
            if (rx_busy_q)
            begin
                rx_shift_q <= {rx_shift_q[14:0], rx_sync_q[1]};
                rx_cnt_q   <= rx_cnt_q + 4'h1;
                if (rx_cnt_q == `BSRP_LAST_BIT)
                begin
                    rx_done_q <= 1'h1;
                    rx_busy_q <= fs_s;
                end
            end
            else if (fs_s)
            begin
                rx_busy_q <= 1'h1;
                rx_cnt_q  <= `BSRP_BIT_ZERO;
            end
        end
    end

    // Word held while next one shifts in
    assign rx_word_ok = rx_done_q & act_sync_q[1];
    always_ff @(posedge clk_n or negedge rstn_in)
    begin
        if (!rstn_in)
            rx_hold_q <= 16'h0000;
        else if (clk_en_in && rx_done_q)
            // Shifter already holds the whole word one edge after bit0
            rx_hold_q <= rx_shift_q;
    end

    // Arbiter: serial port wins ties; controller port waits a cycle
    wire logic host_req = rx_done_q & rx_word_ok;
    wire logic src_iq   = burst_rx_in;
    always_ff @(posedge clk_n or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            host_grant_q <= 1'h0;
            rd_pend_q    <= 1'h0;
            rd_data_q    <= 10'h000;
            usp_rvalid_out <= 1'h0;
            usp_rdata_out  <= 10'h000;
            irq_q        <= 1'h0;
        end
        else if (clk_en_in)
        begin
            host_grant_q   <= host_req;
            usp_rvalid_out <= usp_gnt_out & usp_rd_in;
            if (usp_gnt_out && usp_rd_in)
                usp_rdata_out <= reg_rdata_in;
            if (host_grant_q && rx_hold_q[`BSRP_RW_BIT] == `BSRP_RW_READ)
            begin
                rd_data_q <= reg_rdata_in;
                rd_pend_q <= 1'h1;
            end
            else if (buf_push && !src_iq)
                rd_pend_q <= 1'h0;
            irq_q <= irq_monitoring_adc_in | irq_bci_in | irq_power_control_unit_in;
        end
    end

    assign usp_gnt_out = usp_req_in & ~host_grant_q;
    always_comb
    begin
        if (host_grant_q)
        begin
            reg_addr_out  = rx_hold_q[`BSRP_ADDR_LSB +: `BSRP_ADDR_W];
            reg_wdata_out = rx_hold_q[`BSRP_DATA_LSB +: `BSRP_DATA_W];
            reg_we_out    = (rx_hold_q[`BSRP_RW_BIT] == `BSRP_RW_WRITE);
        end
        else
        begin
            reg_addr_out  = usp_addr_in;
            reg_wdata_out = usp_wdata_in;
            reg_we_out    = usp_gnt_out & ~usp_rd_in;
        end
    end

    // Transmit source: codec in burst, else pending read answer
    assign src_valid = src_iq ? iq_valid_in : rd_pend_q;
    assign src_word  = src_iq ? iq_word_in
                              : {rd_data_q, 6'h00};
    assign buf_push  = src_valid && (buf_cnt_q != 2'h2);
    assign iq_ready_out = src_iq & (buf_cnt_q != 2'h2);
    assign load_tx = (buf_cnt_q != 2'h0) &&
                     (tx_st_q == BSRP_IDLE ||
                      tx_cnt_q == `BSRP_LAST_BIT);
    assign buf_pop = load_tx;

    // Two-entry buffer; a stalled codec loses no sample
    always_ff @(posedge clk_n or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            buf_q[0]  <= 16'h0000;
            buf_q[1]  <= 16'h0000;
            buf_cnt_q <= 2'h0;
            buf_wr_q  <= 1'h0;
            buf_rd_q  <= 1'h0;
        end
        else if (clk_en_in)
        begin
            if (buf_push)
            begin
                buf_q[buf_wr_q] <= src_word;
                buf_wr_q <= ~buf_wr_q;
            end
            if (buf_pop)
                buf_rd_q <= ~buf_rd_q;
            buf_cnt_q <= buf_cnt_q + {1'h0, buf_push} - {1'h0, buf_pop};
        end
    end

    // Transmit shifter; back-to-back words use adjacent framing
    always_ff @(posedge clk_n or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            tx_st_q    <= BSRP_IDLE;
            tx_cnt_q   <= `BSRP_BIT_ZERO;
            tx_shift_q <= 16'h0000;
            tx_fs_q    <= 1'h0;
            tx_line_q  <= 1'h0;
        end
        else if (clk_en_in)
        begin
            tx_fs_q <= load_tx;
            if (tx_st_q == BSRP_SHIFT)
            begin
                tx_line_q  <= tx_shift_q[`BSRP_WORD_BITS-1];
                tx_shift_q <= {tx_shift_q[14:0], 1'h0};
                tx_cnt_q   <= tx_cnt_q + 4'h1;
            end
            if (load_tx)
            begin
                tx_shift_q <= buf_q[buf_rd_q];
                tx_cnt_q   <= `BSRP_BIT_ZERO;
                tx_st_q    <= BSRP_SHIFT;
            end
            else if (tx_st_q == BSRP_SHIFT &&
                     tx_cnt_q == `BSRP_LAST_BIT)
                tx_st_q <= BSRP_IDLE;
        end
    end

    assign link.tx_frame_sync       = tx_fs_q;
    assign link.serial_tx_line      = tx_line_q;
    assign link.host_interrupt_line = irq_q;
endmodule : bsrp_device

// File: design/bsrp_host.sv
`include "bsrp_defines.svh"
module bsrp_host
    import bsrp_pkg::*;
(
    input  wire logic       clock_in,      // Master clock
    input  wire logic       rstn_in,       // Async reset, active low
    input  wire logic       clk_en_in,     // Freezes state when low
    bsrp_link_if.host       link,          // Serial link
    input  wire logic       clk_active_in, // Master clock active
    input  wire logic       cmd_valid_in,  // Command offered
    input  wire logic       cmd_rd_in,     // Read when high
    input  wire bsrp_addr_t cmd_addr_in,   // Register address
    input  wire bsrp_data_t cmd_data_in,   // Write data
    output logic            cmd_ready_out, // Command taken
    output logic            rx_valid_out,  // Word received, one cycle
    output bsrp_word_t      rx_word_out,   // Received word
    output logic            irq_out        // Host interrupt level
);
    logic [1:0] fs_sync_q;
    logic [1:0] dx_sync_q;
    logic [1:0] irq_sync_q;
    bsrp_ser_t  st_q;
    logic [`BSRP_BIT_W-1:0] cnt_q;
    bsrp_word_t sh_q;
    logic       fs_q;
    logic       dr_q;
    logic       rbusy_q;
    logic [`BSRP_BIT_W-1:0] rcnt_q;
    bsrp_word_t rsh_q;
    logic       go;

    // Back to back commands get adjacent framing at the last bit
    assign go = cmd_valid_in & clk_active_in &
                (st_q == BSRP_IDLE || cnt_q == `BSRP_LAST_BIT);
    assign cmd_ready_out = go;
    assign link.master_clock_active_flag = clk_active_in;
    assign link.rx_frame_sync  = fs_q;
    assign link.serial_rx_line = dr_q;

    always_ff @(negedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_q <= BSRP_IDLE;
            cnt_q <= `BSRP_BIT_ZERO;
            sh_q <= 16'h0000;
            fs_q <= 1'h0;
            dr_q <= 1'h0;
        end
        else if (clk_en_in)
        begin
            fs_q <= go;
            if (st_q == BSRP_SHIFT)
            begin
                dr_q  <= sh_q[`BSRP_WORD_BITS-1];
                sh_q  <= {sh_q[14:0], 1'h0};
                cnt_q <= cnt_q + 4'h1;
            end
            if (go)
            begin
                sh_q  <= {cmd_data_in, cmd_addr_in, cmd_rd_in};
                cnt_q <= `BSRP_BIT_ZERO;
                st_q  <= BSRP_SHIFT;
            end
            else if (st_q == BSRP_SHIFT && cnt_q == `BSRP_LAST_BIT)
                st_q <= BSRP_IDLE;
        end
    end

    // Device outputs sampled through two flops
    always_ff @(negedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            fs_sync_q  <= 2'h0;
            dx_sync_q  <= 2'h0;
            irq_sync_q <= 2'h0;
        end
        else if (clk_en_in)
        begin
            fs_sync_q  <= {fs_sync_q[0], link.tx_frame_sync};
            dx_sync_q  <= {dx_sync_q[0], link.serial_tx_line};
            irq_sync_q <= {irq_sync_q[0], link.host_interrupt_line};
        end
    end
    assign irq_out = irq_sync_q[1];

    always_ff @(negedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rbusy_q      <= 1'h0;
            rcnt_q       <= `BSRP_BIT_ZERO;
            rsh_q        <= 16'h0000;
            rx_valid_out <= 1'h0;
            rx_word_out  <= 16'h0000;
        end
        else if (clk_en_in)
        begin
            rx_valid_out <= 1'h0;
            if (rbusy_q)
            begin
                rsh_q  <= {rsh_q[14:0], dx_sync_q[1]};
                rcnt_q <= rcnt_q + 4'h1;
                if (rcnt_q == `BSRP_LAST_BIT)
                begin
                    rx_valid_out <= 1'h1;
                    rx_word_out  <= {rsh_q[14:0], dx_sync_q[1]};
                    rbusy_q      <= fs_sync_q[1];
                end
            end
            else if (fs_sync_q[1])
            begin
                rbusy_q <= 1'h1;
                rcnt_q  <= `BSRP_BIT_ZERO;
            end
        end
    end
endmodule : bsrp_host

// File: tb/bsrp_link_sva.sv
module bsrp_link_sva
(
    input wire logic clock_in,                 // Master clock
    input wire logic rstn_in,                  // Async reset, active low
    input wire logic master_clock_active_flag, // Host clock flag
    input wire logic rx_frame_sync,            // Host frame pulse
    input wire logic serial_rx_line,           // Host data
    input wire logic tx_frame_sync,            // Device frame pulse
    input wire logic serial_tx_line,           // Device data
    input wire logic host_interrupt_line       // Device interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] tx_cnt_q;
    logic [4:0] rx_cnt_q;

    // Bit position since the last pulse; 16 marks the LSB cycle
    always_ff @(negedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            tx_cnt_q <= 5'h00;
        else if (tx_frame_sync)
            tx_cnt_q <= 5'h01;
        else if (tx_cnt_q != 5'h00 && tx_cnt_q != 5'h10)
            tx_cnt_q <= tx_cnt_q + 5'h01;
        else
            tx_cnt_q <= 5'h00;
    end

    always_ff @(negedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            rx_cnt_q <= 5'h00;
        else if (rx_frame_sync)
            rx_cnt_q <= 5'h01;
        else if (rx_cnt_q != 5'h00 && rx_cnt_q != 5'h10)
            rx_cnt_q <= rx_cnt_q + 5'h01;
        else
            rx_cnt_q <= 5'h00;
    end

    default clocking cb @(negedge clock_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_tx_quiet;
        !tx_frame_sync [*8];
    endsequence
    sequence s_rx_quiet;
        !rx_frame_sync [*8];
    endsequence

    chk_tx_pulse_width: assert property (tx_frame_sync |=> s_tx_quiet)
        else $error("device frame pulse too long");
    chk_rx_pulse_width: assert property (rx_frame_sync |=> s_rx_quiet)
        else $error("host frame pulse too long");
    chk_tx_word_spacing: assert property
        (tx_frame_sync |-> (tx_cnt_q == 5'h00 || tx_cnt_q == 5'h10))
        else $error("device pulse off the word boundary");
    chk_rx_word_spacing: assert property
        (rx_frame_sync |-> (rx_cnt_q == 5'h00 || rx_cnt_q == 5'h10))
        else $error("host pulse off the word boundary");
    chk_tx_no_restart: assert property
        (tx_cnt_q inside {[5'h01:5'h0f]} |-> !tx_frame_sync)
        else $error("device pulse inside a word");
    chk_rx_needs_active: assert property
        (rx_frame_sync |-> master_clock_active_flag)
        else $error("host access while clock flag low");
    chk_tx_reset_idle: assert property
        ($rose(rstn_in) |-> !tx_frame_sync && !serial_tx_line
            && !host_interrupt_line)
        else $error("device outputs not idle after reset");
    chk_rx_reset_idle: assert property
        ($rose(rstn_in) |-> !rx_frame_sync && !serial_rx_line)
        else $error("host outputs not idle after reset");
endmodule : bsrp_link_sva

// File: tb/tb.sv
module tb import bsrp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock_in, rstn_in, clk_active_in, cmd_valid_in, cmd_rd_in;
    logic       cmd_ready_out, rx_valid_out, irq_out, burst_rx_in;
    logic       iq_valid_in, iq_ready_out, usp_req_in, usp_rd_in;
    logic       usp_gnt_out, usp_rvalid_out, reg_we_out;
    logic [2:0] irq_in;
    bsrp_addr_t cmd_addr_in, usp_addr_in, reg_addr_out;
    bsrp_data_t cmd_data_in, usp_wdata_in, usp_rdata_out, reg_wdata_out;
    bsrp_word_t rx_word_out, iq_word_in;
    bsrp_data_t regs [32];
    int         err_total, samples_checked, cyc;

    bsrp_link_if link ();
    bsrp_device bsrp_device_inst (.clock_in(clock_in), .rstn_in(rstn_in),
        .clk_en_in(1'b1), .link(link), .burst_rx_in(burst_rx_in),
        .iq_valid_in(iq_valid_in), .iq_word_in(iq_word_in),
        .iq_ready_out(iq_ready_out), .usp_req_in(usp_req_in),
        .usp_rd_in(usp_rd_in), .usp_addr_in(usp_addr_in),
        .usp_wdata_in(usp_wdata_in), .usp_gnt_out(usp_gnt_out),
        .usp_rdata_out(usp_rdata_out), .usp_rvalid_out(usp_rvalid_out),
        .reg_we_out(reg_we_out), .reg_addr_out(reg_addr_out),
        .reg_wdata_out(reg_wdata_out), .reg_rdata_in(regs[reg_addr_out]),
        .irq_monitoring_adc_in(irq_in[0]), .irq_bci_in(irq_in[1]),
        .irq_power_control_unit_in(irq_in[2]));
    bsrp_host bsrp_host_inst (.clock_in(clock_in), .rstn_in(rstn_in),
        .clk_en_in(1'b1), .link(link), .clk_active_in(clk_active_in),
        .cmd_valid_in(cmd_valid_in), .cmd_rd_in(cmd_rd_in),
        .cmd_addr_in(cmd_addr_in), .cmd_data_in(cmd_data_in),
        .cmd_ready_out(cmd_ready_out), .rx_valid_out(rx_valid_out),
        .rx_word_out(rx_word_out), .irq_out(irq_out));
    bsrp_link_sva bsrp_link_sva_inst (.clock_in(clock_in), .rstn_in(rstn_in),
        .master_clock_active_flag(link.master_clock_active_flag),
        .rx_frame_sync(link.rx_frame_sync),
        .serial_rx_line(link.serial_rx_line),
        .tx_frame_sync(link.tx_frame_sync),
        .serial_tx_line(link.serial_tx_line),
        .host_interrupt_line(link.host_interrupt_line));

    // Register file behind the internal bus, read combinationally
    always @(negedge clock_in)
        if (reg_we_out === 1'b1)
            regs[reg_addr_out] <= reg_wdata_out;

    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    always @(posedge clock_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic check(input string nm, input logic [15:0] e,
                         input logic [15:0] s);
        samples_checked++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // Ready is sampled mid-cycle so the falling edge that takes it is known
    task automatic wait_take(input int sel);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 300 && !r; i++)
        begin
            #2;
            r = sel == 0 ? cmd_ready_out === 1'b1 :
                sel == 1 ? iq_ready_out === 1'b1 : usp_gnt_out === 1'b1;
            @(negedge clock_in);
            if (!r)
                @(posedge clock_in);
        end
        check("handshake", 16'h0001, {15'h0000, r});
    endtask : wait_take

    task automatic wait_ans(input int sel, output bsrp_word_t w);
        w = 16'hxxxx;
        for (int i = 0; i < 400; i++)
        begin
            @(negedge clock_in);
            #1;
            if ((sel == 0 ? rx_valid_out : usp_rvalid_out) === 1'b1)
            begin
                w = sel == 0 ? rx_word_out : {usp_rdata_out, 6'h00};
                return;
            end
        end
    endtask : wait_ans

    task automatic cmd(input logic rd, input bsrp_addr_t a,
                       input bsrp_data_t d);
        @(posedge clock_in);
        cmd_valid_in <= 1'b1;
        cmd_rd_in <= rd;
        cmd_addr_in <= a;
        cmd_data_in <= d;
        wait_take(0);
    endtask : cmd

    task automatic controller_serial_port(input logic rd, input bsrp_addr_t a,
                       input bsrp_data_t d);
        @(posedge clock_in);
        usp_req_in <= 1'b1;
        usp_rd_in <= rd;
        usp_addr_in <= a;
        usp_wdata_in <= d;
        wait_take(2);
        @(posedge clock_in) usp_req_in <= 1'b0;
    endtask : controller_serial_port

    task automatic reg_is(input bsrp_addr_t a, input bsrp_data_t v);
        for (int i = 0; i < 80 && regs[a] !== v; i++)
            @(posedge clock_in);
        check("register", {6'h00, v}, {6'h00, regs[a]});
    endtask : reg_is

    task automatic t_write_read();
        bsrp_word_t w;
        bsrp_addr_t a [2] = '{5'h01, 5'h1f};
        bsrp_data_t d [2] = '{10'h155, 10'h2aa};
        for (int i = 0; i < 2; i++)
        begin
            cmd(1'b0, a[i], d[i]);
            @(posedge clock_in) cmd_valid_in <= 1'b0;
            reg_is(a[i], d[i]);
            // Inverted data on a read must not reach the register
            cmd(1'b1, a[i], ~d[i]);
            @(posedge clock_in) cmd_valid_in <= 1'b0;
            wait_ans(0, w);
            check("read_word", {d[i], 6'h00}, w);
            reg_is(a[i], d[i]);
        end
        $display("test write_read done");
    endtask : t_write_read

    task automatic t_adjacent();
        bsrp_word_t w;
        fork
            begin
                cmd(1'b0, 5'h02, 10'h0f0);
                cmd(1'b0, 5'h03, 10'h30f);
                cmd(1'b1, 5'h02, 10'h000);
                cmd(1'b1, 5'h03, 10'h000);
                @(posedge clock_in) cmd_valid_in <= 1'b0;
            end
            begin
                wait_ans(0, w);
                check("adj_first", {10'h0f0, 6'h00}, w);
                wait_ans(0, w);
                check("adj_second", {10'h30f, 6'h00}, w);
            end
        join
        $display("test adjacent done");
    endtask : t_adjacent

    task automatic t_burst();
        bsrp_word_t w;
        bsrp_word_t iqs [3] = '{16'h8001, 16'h7ffe, 16'hc3a5};
        @(posedge clock_in) burst_rx_in <= 1'b1;
        // Three words fit in the shifter and the two-entry buffer, so none is refused
        fork
            begin
                for (int i = 0; i < 3; i++)
                begin
                    @(posedge clock_in);
                    iq_valid_in <= 1'b1;
                    iq_word_in <= iqs[i];
                    wait_take(1);
                end
                @(posedge clock_in) iq_valid_in <= 1'b0;
            end
            begin
                cmd(1'b1, 5'h1f, 10'h000);
                @(posedge clock_in) cmd_valid_in <= 1'b0;
            end
            for (int i = 0; i < 3; i++)
            begin
                wait_ans(0, w);
                check("iq_word", iqs[i], w);
            end
        join
        @(posedge clock_in) burst_rx_in <= 1'b0;
        wait_ans(0, w);
        check("late_read", {10'h2aa, 6'h00}, w);
        $display("test burst done");
    endtask : t_burst

    task automatic t_usp();
        bsrp_word_t w;
        bsrp_word_t v;
        controller_serial_port(1'b0, 5'h07, 10'h1c3);
        reg_is(5'h07, 10'h1c3);
        fork
            begin
                cmd(1'b1, 5'h01, 10'h000);
                @(posedge clock_in) cmd_valid_in <= 1'b0;
                wait_ans(0, w);
            end
            controller_serial_port(1'b1, 5'h07, 10'h000);
            wait_ans(1, v);
        join
        check("serial_route", {10'h155, 6'h00}, w);
        check("usp_route", {10'h1c3, 6'h00}, v);
        $display("test arbiter done");
    endtask : t_usp

    // Host must hold off while the clock flag is low
    task automatic t_inactive();
        @(posedge clock_in) clk_active_in <= 1'b0;
        cmd_valid_in <= 1'b1;
        cmd_rd_in <= 1'b0;
        cmd_addr_in <= 5'h04;
        cmd_data_in <= 10'h3c3;
        repeat (40)
        begin
            @(posedge clock_in);
            check("refused", 16'h0000, {15'h0000, cmd_ready_out});
        end
        cmd_valid_in <= 1'b0;
        clk_active_in <= 1'b1;
        check("no_write", 16'h0000, {6'h00, regs[5'h04]});
        $display("test inactive done");
    endtask : t_inactive

    task automatic wait_irq(input logic v);
        for (int j = 0; j < 10 && irq_out !== v; j++)
            @(posedge clock_in);
        check("irq", {15'h0000, v}, {15'h0000, irq_out});
    endtask : wait_irq

    task automatic t_irq();
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock_in) irq_in <= 3'h1 << i;
            wait_irq(1'b1);
            @(posedge clock_in) irq_in <= 3'h0;
            wait_irq(1'b0);
        end
        $display("test interrupt done");
    endtask : t_irq

    initial
    begin
        rstn_in = 1'b0;
        clk_active_in = 1'b1;
        {cmd_valid_in, cmd_rd_in, burst_rx_in, iq_valid_in} = 4'h0;
        {usp_req_in, usp_rd_in} = 2'h0;
        irq_in = 3'h0;
        cmd_addr_in = 5'h00;
        usp_addr_in = 5'h00;
        cmd_data_in = 10'h000;
        usp_wdata_in = 10'h000;
        iq_word_in = 16'h0000;
        err_total = 0;
        samples_checked = 0;
        cyc = 0;
        for (int i = 0; i < 32; i++)
            regs[i] = 10'h000;
        repeat (5) @(posedge clock_in);
        rstn_in <= 1'b1;
        t_write_read();
        t_adjacent();
        t_burst();
        t_usp();
        t_inactive();
        t_irq();
        stop_test();
    end
endmodule : tb
